//--- include/rdbd_cfg.svh
// rdbd register offsets, field positions, reset values
`ifndef RDBD_CFG_SVH
`define RDBD_CFG_SVH
`define RDBD_AW 8
`define RDBD_OFS_CTRL 8'h00
`define RDBD_OFS_STAT 8'h04
`define RDBD_OFS_MASK 8'h08
`define RDBD_OFS_LENPOS 8'h0C
`define RDBD_OFS_ADDR 8'h10
`define RDBD_OFS_MODE 8'h14
`define RDBD_OFS_QSTAT 8'h18
`define RDBD_OFS_QVALID 8'h1C
`define RDBD_CA_BIT 31
`define RDBD_VA_BIT 30
`define RDBD_VT_BIT 29
`define RDBD_LEN_HI 30
`define RDBD_LEN_LO 16
`define RDBD_POS_HI 8
`define RDBD_POS_LO 0
`define RDBD_ST_DONE 0
`define RDBD_ST_ODD 1
`define RDBD_ST_ALIGN 2
`define RDBD_ST_CHAIN 3
`define RDBD_ST_CMP 4
`define RDBD_ST_W 5
`define RDBD_CTRL_EN_RST 1'b1
`define RDBD_MASK_RST 5'h00
`endif

//--- include/rdbd_pkg.sv
// rdbd shared types and field helpers
package rdbd_pkg;
  typedef enum logic [1:0] {
    RDBD_MODE_PHYS,
    RDBD_MODE_SYS_VIRT_PTR,
    RDBD_MODE_PHYS_PTR
  } rdbd_mode_e;
  typedef enum logic [1:0] {
    RDBD_IDLE,
    RDBD_DECODE,
    RDBD_READY
  } rdbd_fsm_e;
  typedef struct packed {
    logic [31:0] rx_desc_word_one;
    logic [31:0] rx_desc_word_two;
    logic [31:0] rx_desc_word_three;
  } rdbd_desc_s;
  typedef struct packed {
    logic [14:0] buffer_length_field;
    logic [8:0] page_position_field;
    logic [31:0] addr;
    rdbd_mode_e mode;
    logic chain;
  } rdbd_dec_s;
  typedef struct packed {
    logic overflow;
    logic late_collision;
    logic runt;
    logic runt_short;
    logic watchdog;
  } rdbd_cmp_kind_s;
  typedef struct packed {
    logic runt_frame_status;
    logic too_long_status;
    logic collision_status;
    logic frame_type_status;
    logic dribbling_status;
    logic crc_status;
    logic [8:0] other;
  } rdbd_rx_stat_s;
  typedef struct packed {
    rdbd_fsm_e fsm;
    rdbd_desc_s desc;
    rdbd_dec_s dec;
    logic odd_len;
    logic misalign;
    logic next_valid;
    logic desc_close;
    logic ctrl_en;
    logic [4:0] stat;
    logic [4:0] mask;
    rdbd_rx_stat_s qstat;
    rdbd_rx_stat_s qvalid;
    logic dp_act;
    logic dp_wr;
    logic [7:0] dp_addr;
    logic [31:0] hrdata;
  } rdbd_state_s;
  function automatic logic [14:0] rdbd_len(input logic [31:0] w);
    rdbd_len = w[30:16];
  endfunction
  function automatic logic [8:0] rdbd_pos(input logic [31:0] w);
    rdbd_pos = w[8:0];
  endfunction
endpackage

//--- logic/rdbd_addr_sel.sv
// rdbd descriptor word two and three field decode
`timescale 1ns/100ps
`default_nettype none
`include "rdbd_cfg.svh"
module rdbd_addr_sel (
  input wire rdbd_pkg::rdbd_desc_s desc,
  output rdbd_pkg::rdbd_dec_s dec,
  output logic misalign
);
  import rdbd_pkg::*;
  logic va;
  logic vt;
  always_comb begin
    va = desc.rx_desc_word_one[`RDBD_VA_BIT];
    vt = desc.rx_desc_word_one[`RDBD_VT_BIT];
    // unused bits never reach any output
    dec.buffer_length_field = rdbd_len(desc.rx_desc_word_two); // [RL1] [RL2]
    // position only means something under virtual addressing
    dec.page_position_field = va ? rdbd_pos(desc.rx_desc_word_two)
                                 : 9'h000; // [RL4] [RL5]
    dec.addr = desc.rx_desc_word_three; // [RL7] [RL9] [RL10]
    dec.chain = desc.rx_desc_word_one[`RDBD_CA_BIT]; // [RL10]
    if (!va) begin
      dec.mode = RDBD_MODE_PHYS; // [RL14]
    end else if (vt) begin
      dec.mode = RDBD_MODE_PHYS_PTR; // [RL8] [RL14]
    end else begin
      dec.mode = RDBD_MODE_SYS_VIRT_PTR; // [RL8] [RL14]
    end
    // flags software slips; the buffer itself is still decoded
    misalign = !dec.chain && (va ? dec.page_position_field[0]
                                 : dec.addr[0]); // [RL6]
  end
endmodule
`default_nettype wire

//--- logic/rdbd_stat_qual.sv
// rdbd receive status validity qualification
`timescale 1ns/100ps
`default_nettype none
module rdbd_stat_qual (
  input wire rdbd_pkg::rdbd_cmp_kind_s kind,
  input wire rdbd_pkg::rdbd_rx_stat_s raw,
  output rdbd_pkg::rdbd_rx_stat_s valid,
  output rdbd_pkg::rdbd_rx_stat_s qual
);
  import rdbd_pkg::*;
  always_comb begin
    valid = '{default: '1};
    if (kind.overflow) begin
      valid.runt_frame_status = 1'b0; // [RL11]
      valid.collision_status = 1'b0; // [RL11]
    end
    if (kind.watchdog) begin
      valid.collision_status = 1'b0; // [RL11]
    end
    if (kind.runt_short) begin
      valid.frame_type_status = 1'b0; // [RL13]
    end
    // any abnormal end spoils dribble and crc
    if (kind.overflow || kind.watchdog || kind.late_collision ||
        kind.runt || kind.runt_short) begin
      valid.dribbling_status = 1'b0; // [RL11] [RL12] [RL13]
      valid.crc_status = 1'b0; // [RL11] [RL12] [RL13]
    end
    qual = raw & valid;
  end
endmodule
`default_nettype wire

//--- logic/rdbd_top.sv
// rdbd receive descriptor buffer decode with ahb-lite registers
//
// The placing of the registers and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "rdbd_cfg.svh"
// Contract
// [RL1] unused descriptor bits ignored, never written
// [RL2] word two bits 30:16 give byte length
// [RL3] software gives even buffer lengths
// [RL4] word two bits 8:0 give page position
// [RL5] page position used only when virtual
// [RL6] software keeps buffers word aligned
// [RL7] virtual: word three is entry address
// [RL8] translation flag picks entry address type
// [RL9] physical: word three is buffer address
// [RL10] chain flag: word three is next descriptor
// [RL11] overflow and timeout spoil some status bits
// [RL12] late collision, runt spoil dribble, crc
// [RL13] short runt also spoils frame type
// [RL14] two flags select addressing mode
// [RL15] chain descriptor first word left untouched
// [RL16] decode words before any buffer write
module rdbd_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic desc_valid,
  output logic desc_ready,
  input wire rdbd_pkg::rdbd_desc_s desc_in,
  output rdbd_pkg::rdbd_dec_s dec_out,
  output logic data_write_ok,
  input wire logic buf_done,
  output logic desc_close,
  output logic next_desc_valid,
  output logic [31:0] next_desc_addr,
  input wire logic cmp_valid,
  input wire rdbd_pkg::rdbd_cmp_kind_s cmp_kind,
  input wire rdbd_pkg::rdbd_rx_stat_s cmp_raw,
  output rdbd_pkg::rdbd_rx_stat_s stat_out,
  output rdbd_pkg::rdbd_rx_stat_s stat_valid,
  output logic irq
);
  import rdbd_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  rdbd_state_s s_q;
  rdbd_state_s s_d;
  rdbd_dec_s dec_c;
  logic misalign_c;
  rdbd_rx_stat_s qvalid_c;
  rdbd_rx_stat_s qual_c;
  logic addr_ok;
  logic wr_en;
  logic [4:0] set_c;
  logic [4:0] clr_c;

  rdbd_addr_sel u_addr_sel (
    .desc(s_q.desc),
    .dec(dec_c),
    .misalign(misalign_c)
  );

  rdbd_stat_qual u_stat_qual (
    .kind(cmp_kind),
    .raw(cmp_raw),
    .valid(qvalid_c),
    .qual(qual_c)
  );

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d = s_q;
    set_c = 5'h00;
    clr_c = 5'h00;
    s_d.next_valid = 1'b0;
    s_d.desc_close = 1'b0;
    // bus address phase; only whole-word transfers are supported
    addr_ok = hsel && hready && htrans[1];
    wr_en = s_q.dp_act && s_q.dp_wr;
    s_d.dp_act = addr_ok;
    if (addr_ok) begin
      s_d.dp_wr = hwrite;
      s_d.dp_addr = haddr[7:0];
    end
    if (addr_ok && !hwrite) begin
      unique case (haddr[7:0])
        `RDBD_OFS_CTRL: s_d.hrdata = {31'h0, s_q.ctrl_en};
        `RDBD_OFS_STAT: s_d.hrdata = {27'h0, s_q.stat};
        `RDBD_OFS_MASK: s_d.hrdata = {27'h0, s_q.mask};
        `RDBD_OFS_LENPOS: s_d.hrdata = {1'b0,
          s_q.dec.buffer_length_field, 7'h00,
          s_q.dec.page_position_field}; // [RL1]
        `RDBD_OFS_ADDR: s_d.hrdata = s_q.dec.addr;
        `RDBD_OFS_MODE: s_d.hrdata = {26'h0, s_q.fsm, s_q.misalign,
          s_q.dec.chain, s_q.dec.mode};
        `RDBD_OFS_QSTAT: s_d.hrdata = {17'h0, s_q.qstat};
        `RDBD_OFS_QVALID: s_d.hrdata = {17'h0, s_q.qvalid};
        default: s_d.hrdata = 32'h0000_0000;
      endcase
    end
    // data phase writes
    if (wr_en) begin
      unique case (s_q.dp_addr)
        `RDBD_OFS_CTRL: s_d.ctrl_en = hwdata[0];
        `RDBD_OFS_STAT: clr_c = hwdata[4:0];
        `RDBD_OFS_MASK: s_d.mask = hwdata[4:0];
        default: s_d.ctrl_en = s_q.ctrl_en;
      endcase
    end
    // descriptor walk
    unique case (s_q.fsm)
      RDBD_IDLE: begin
        // words are latched before any data moves
        if (desc_valid && s_q.ctrl_en) begin
          s_d.desc = desc_in; // [RL16]
          s_d.fsm = RDBD_DECODE; // [RL16]
        end
      end
      RDBD_DECODE: begin
        s_d.dec = dec_c; // [RL16]
        s_d.misalign = misalign_c;
        s_d.odd_len = dec_c.buffer_length_field[0]; // [RL3]
        set_c[`RDBD_ST_ODD] = dec_c.buffer_length_field[0]; // [RL3]
        set_c[`RDBD_ST_ALIGN] = misalign_c; // [RL6]
        if (dec_c.chain) begin
          // chained: no buffer, and nothing written back
          s_d.next_valid = 1'b1; // [RL10] [RL15]
          set_c[`RDBD_ST_CHAIN] = 1'b1;
          s_d.fsm = RDBD_IDLE;
        end else begin
          s_d.fsm = RDBD_READY;
        end
      end
      RDBD_READY: begin
        if (buf_done) begin
          s_d.desc_close = 1'b1;
          set_c[`RDBD_ST_DONE] = 1'b1;
          s_d.fsm = RDBD_IDLE;
        end
      end
      default: s_d.fsm = RDBD_IDLE;
    endcase
    if (cmp_valid) begin
      s_d.qstat = qual_c; // [RL11] [RL12] [RL13]
      s_d.qvalid = qvalid_c;
      set_c[`RDBD_ST_CMP] = 1'b1;
    end
    // a new event beats a clear in the same cycle
    s_d.stat = (s_q.stat & ~clr_c) | set_c;
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
      s_q.fsm <= RDBD_IDLE;
      s_q.ctrl_en <= `RDBD_CTRL_EN_RST;
      s_q.mask <= `RDBD_MASK_RST;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // zero wait states; a read is sampled in its address phase
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_q.hrdata;
  assign desc_ready = (s_q.fsm == RDBD_IDLE) && s_q.ctrl_en;
  assign data_write_ok = (s_q.fsm == RDBD_READY); // [RL16]
  assign dec_out = s_q.dec;
  assign desc_close = s_q.desc_close;
  assign next_desc_valid = s_q.next_valid;
  assign next_desc_addr = s_q.dec.addr;
  assign stat_out = s_q.qstat;
  assign stat_valid = s_q.qvalid;
  assign irq = |(s_q.stat & s_q.mask);

  ////////////////////////////////////////////////////////////////////////
  chk_capture_first: assert property ( // [RL16]
    @(posedge hclk) disable iff (!hresetn)
    desc_valid && desc_ready |=> s_q.fsm == RDBD_DECODE ##1
      (data_write_ok || next_desc_valid))
    else $error("descriptor not decoded before buffer use");

  chk_no_early_write: assert property ( // [RL16]
    @(posedge hclk) disable iff (!hresetn)
    $rose(data_write_ok) |-> $past(s_q.fsm) == RDBD_DECODE)
    else $error("buffer write allowed without decode");

  chk_length_field: assert property ( // [RL2]
    @(posedge hclk) disable iff (!hresetn)
    s_q.fsm == RDBD_DECODE |=>
      dec_out.buffer_length_field ==
      $past(s_q.desc.rx_desc_word_two[30:16]))
    else $error("buffer length not taken from bits 30:16");

  chk_position_use: assert property ( // [RL4] [RL5]
    @(posedge hclk) disable iff (!hresetn)
    s_q.fsm == RDBD_DECODE |=> dec_out.page_position_field ==
      ($past(s_q.desc.rx_desc_word_one[30]) ?
       $past(s_q.desc.rx_desc_word_two[8:0]) : 9'h000))
    else $error("page position used wrongly");

  chk_phys_mode: assert property ( // [RL9] [RL14]
    @(posedge hclk) disable iff (!hresetn)
    s_q.fsm == RDBD_DECODE && !s_q.desc.rx_desc_word_one[30] |=>
      dec_out.mode == RDBD_MODE_PHYS &&
      dec_out.addr == $past(s_q.desc.rx_desc_word_three))
    else $error("physical buffer address wrong");

  chk_virt_mode: assert property ( // [RL7] [RL8] [RL14]
    @(posedge hclk) disable iff (!hresetn)
    s_q.fsm == RDBD_DECODE && s_q.desc.rx_desc_word_one[30] |=>
      dec_out.mode == ($past(s_q.desc.rx_desc_word_one[29]) ?
        RDBD_MODE_PHYS_PTR : RDBD_MODE_SYS_VIRT_PTR) &&
      dec_out.addr == $past(s_q.desc.rx_desc_word_three))
    else $error("entry pointer mode or address wrong");

  chk_chain_next: assert property ( // [RL10]
    @(posedge hclk) disable iff (!hresetn)
    s_q.fsm == RDBD_DECODE && s_q.desc.rx_desc_word_one[31] |=>
      next_desc_valid && !data_write_ok &&
      next_desc_addr == $past(s_q.desc.rx_desc_word_three))
    else $error("chain descriptor not followed");

  chk_chain_untouched: assert property ( // [RL15]
    @(posedge hclk) disable iff (!hresetn)
    next_desc_valid |-> !desc_close ##1 !desc_close)
    else $error("chain descriptor closed");

  chk_overflow_mask: assert property ( // [RL11]
    @(posedge hclk) disable iff (!hresetn)
    cmp_valid && cmp_kind.overflow && !cmp_kind.runt_short |=>
      !stat_valid.runt_frame_status &&
      !stat_valid.collision_status && !stat_valid.crc_status &&
      stat_valid.too_long_status && stat_valid.frame_type_status &&
      stat_valid.other == 9'h1FF)
    else $error("overflow validity wrong");

  chk_watchdog_mask: assert property ( // [RL11]
    @(posedge hclk) disable iff (!hresetn)
    cmp_valid && cmp_kind == 5'h01 |=> stat_valid.runt_frame_status &&
      !stat_valid.collision_status && !stat_valid.dribbling_status)
    else $error("watchdog validity wrong");

  chk_runt_mask: assert property ( // [RL12]
    @(posedge hclk) disable iff (!hresetn)
    cmp_valid && (cmp_kind == 5'h08 || cmp_kind == 5'h04) |=>
      stat_valid == 15'h79FF &&
      stat_out == ($past(cmp_raw) & 15'h79FF))
    else $error("runt or late collision validity wrong");

  chk_short_runt: assert property ( // [RL13]
    @(posedge hclk) disable iff (!hresetn)
    cmp_valid && (cmp_kind == 5'h02 || cmp_kind == 5'h06) |=>
      stat_valid == 15'h71FF)
    else $error("short runt validity wrong");

  chk_sticky_set: assert property (
    @(posedge hclk) disable iff (!hresetn)
    next_desc_valid |-> s_q.stat[`RDBD_ST_CHAIN] ##1
      s_q.stat[`RDBD_ST_CHAIN] || $past(wr_en))
    else $error("chain event lost");

  chk_lenpos_unused: assert property ( // [RL1]
    @(posedge hclk) disable iff (!hresetn)
    addr_ok && !hwrite && haddr[7:0] == `RDBD_OFS_LENPOS |=>
      hrdata[31] == 1'b0 && hrdata[15:9] == 7'h00)
    else $error("unused descriptor bits shown");

  chk_desc_refused: assert property ( // [RL16]
    @(posedge hclk) disable iff (!hresetn)
    s_q.fsm != RDBD_IDLE || !s_q.ctrl_en |=> $stable(s_q.desc))
    else $error("descriptor taken while busy or disabled");

  chk_stray_done: assert property ( // [RL16]
    @(posedge hclk) disable iff (!hresetn)
    buf_done && !data_write_ok |=> !desc_close)
    else $error("buffer completion taken outside a buffer");

  chk_close_pulse: assert property ( // [RL16]
    @(posedge hclk) disable iff (!hresetn)
    data_write_ok && buf_done |=> desc_close && !data_write_ok ##1
      !desc_close)
    else $error("buffer completion not closed once");

  chk_next_pulse: assert property ( // [RL10]
    @(posedge hclk) disable iff (!hresetn)
    next_desc_valid |-> s_q.fsm == RDBD_IDLE ##1 !next_desc_valid)
    else $error("chain pulse longer than a cycle");

  chk_event_wins: assert property (
    @(posedge hclk) disable iff (!hresetn)
    cmp_valid |=> s_q.stat[`RDBD_ST_CMP])
    else $error("completion event lost to a clear");

  chk_stat_clear: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_en && s_q.dp_addr == `RDBD_OFS_STAT && hwdata[`RDBD_ST_CMP] &&
      !cmp_valid |=> !s_q.stat[`RDBD_ST_CMP])
    else $error("completion status not cleared");

  chk_dec_holds: assert property ( // [RL16]
    @(posedge hclk) disable iff (!hresetn)
    data_write_ok && !buf_done |=> data_write_ok && $stable(dec_out))
    else $error("decode changed under a buffer");

  chk_stat_masked: assert property ( // [RL11] [RL12] [RL13]
    @(posedge hclk) disable iff (!hresetn)
    cmp_valid |=> stat_out == ($past(cmp_raw) & stat_valid))
    else $error("status not limited to valid bits");

  chk_mask_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_en && s_q.dp_addr == `RDBD_OFS_MASK |=>
      s_q.mask == $past(hwdata[4:0]))
    else $error("mask write not applied");

  chk_mode_read: assert property ( // [RL14]
    @(posedge hclk) disable iff (!hresetn)
    addr_ok && !hwrite && haddr[7:0] == `RDBD_OFS_MODE |=>
      hrdata[31:6] == 26'h0 && hrdata[1:0] == $past(s_q.dec.mode))
    else $error("mode readback wrong");

  chk_ctrl_read: assert property (
    @(posedge hclk) disable iff (!hresetn)
    addr_ok && !hwrite && haddr[7:0] == `RDBD_OFS_CTRL |=>
      hrdata == {31'h0, $past(s_q.ctrl_en)})
    else $error("control readback wrong");

  chk_addr_read: assert property ( // [RL7] [RL9] [RL10]
    @(posedge hclk) disable iff (!hresetn)
    addr_ok && !hwrite && haddr[7:0] == `RDBD_OFS_ADDR |=>
      hrdata == $past(s_q.dec.addr))
    else $error("address readback wrong");

  chk_unmapped_read: assert property (
    @(posedge hclk) disable iff (!hresetn)
    addr_ok && !hwrite && haddr[7:0] > `RDBD_OFS_QVALID |=>
      hrdata == 32'h0000_0000)
    else $error("unmapped register not read as zero");
endmodule
`default_nettype wire

//--- sim/rdbd_host_mem.sv
// host memory model offering receive descriptor words to the engine
`timescale 1ns/100ps
`default_nettype none
module rdbd_host_mem (
  input wire logic hclk,
  input wire logic go,
  input wire logic [3:0] lat,
  input wire rdbd_pkg::rdbd_desc_s word_in,
  input wire logic desc_ready,
  output logic desc_valid,
  output rdbd_pkg::rdbd_desc_s desc_in
);
  import rdbd_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  // lat gives a slow fetch; idle bus toggles every bit, so the last word shows every other cycle
  initial begin
    desc_valid = 1'b0;
    desc_in = '0;
    forever begin
      @(posedge hclk);
      if (go) begin
        repeat (lat) begin
          desc_in <= ~desc_in;
          @(posedge hclk);
        end
        desc_valid <= 1'b1;
        desc_in <= word_in;
        do @(posedge hclk); while (!desc_ready);
        desc_valid <= 1'b0;
        desc_in <= ~word_in;
      end else begin
        desc_in <= ~desc_in;
      end
    end
  end
endmodule
`default_nettype wire

//--- sim/tb.sv
// self-checking bench for the receive descriptor decode block
`timescale 1ns/100ps
`default_nettype none
`include "rdbd_cfg.svh"
module tb;
  import rdbd_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, go, desc_ready, desc_valid, data_write_ok, buf_done;
  logic desc_close, next_desc_valid, cmp_valid, irq, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, next_desc_addr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] lat;
  wire logic hready;
  rdbd_desc_s word_in, desc_in;
  rdbd_dec_s dec_out;
  rdbd_cmp_kind_s cmp_kind;
  rdbd_rx_stat_s cmp_raw, stat_out, stat_valid;
  int failures, n_tests, cyc;
  // rows: even lengths, aligned buffers, unused bits set in row 0
  logic [31:0] w1 [4] = '{32'h0, 32'h4000_0000, 32'h6000_0000, 32'hA000_0000};
  logic [31:0] w2 [4] = '{32'h8040_FFFF, 32'h7FFE_0010, 32'h0002_0102, 32'h0};
  logic [31:0] w3 [4] = '{32'h0001_2340, 32'h8000_0ABC, 32'hFFFF_FFFE,
    32'h0000_2000};
  logic [1:0] md [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
  logic [3:0] lt [4] = '{4'h0, 4'h3, 4'h1, 4'h2};
  // overflow, late collision, runt, short runt, watchdog
  logic [4:0] ck [5] = '{5'h10, 5'h08, 5'h04, 5'h06, 5'h01};
  logic [14:0] cv [5] = '{15'h29FF, 15'h79FF, 15'h79FF, 15'h71FF, 15'h69FF};
  localparam logic [14:0] RAW = 15'h6AB5;
  assign hready = hreadyout;
  always #5 hclk = ~hclk;
  rdbd_top rdbd_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .desc_valid(desc_valid),
    .desc_ready(desc_ready), .desc_in(desc_in), .dec_out(dec_out),
    .data_write_ok(data_write_ok), .buf_done(buf_done),
    .desc_close(desc_close), .next_desc_valid(next_desc_valid),
    .next_desc_addr(next_desc_addr), .cmp_valid(cmp_valid),
    .cmp_kind(cmp_kind), .cmp_raw(cmp_raw), .stat_out(stat_out),
    .stat_valid(stat_valid), .irq(irq));
  rdbd_host_mem rdbd_host_mem_inst (.hclk(hclk), .go(go), .lat(lat),
    .word_in(word_in), .desc_ready(desc_ready), .desc_valid(desc_valid),
    .desc_in(desc_in));
  ////////////////////////////////////////////////////////////////////////
  task automatic tick;
    @(posedge hclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // one idle cycle ahead of each transfer avoids the stale read hazard
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    tick;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do tick; while (!hreadyout);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    do tick; while (!hreadyout);
    if (!w)
      chk(hrdata, d);
    chk(32'(hresp), 32'h0);
  endtask
  task automatic run_desc(input int i);
    int n;
    logic [31:0] pos_exp;
    n = 0;
    tick;
    word_in <= {w1[i], w2[i], w3[i]};
    lat <= lt[i];
    go <= 1'b1;
    tick;
    go <= 1'b0;
    do begin
      tick;
      #1;
      n++;
    end while (!(data_write_ok | next_desc_valid) && n < 40);
    pos_exp = w1[i][30] ? 32'(w2[i][8:0]) : 32'h0;
    chk(dec_out.addr, w3[i]);
    chk(32'(dec_out.buffer_length_field), 32'(w2[i][30:16]));
    chk(32'(dec_out.chain), 32'(w1[i][31]));
    chk(32'(dec_out.page_position_field), pos_exp);
    if (w1[i][31]) begin
      chk(next_desc_addr, w3[i]);
      chk(32'(data_write_ok), 32'h0);
      tick;
      #1;
      chk(32'(desc_close), 32'h0);
    end else begin
      chk(32'(dec_out.mode), 32'(md[i]));
      chk(32'(data_write_ok), 32'h1);
      tick;
      buf_done <= 1'b1;
      tick;
      buf_done <= 1'b0;
      #1;
      chk(32'(desc_close), 32'h1);
    end
  endtask
  task automatic run_cmp(input int i);
    tick;
    cmp_kind <= ck[i];
    cmp_raw <= RAW;
    cmp_valid <= 1'b1;
    tick;
    cmp_valid <= 1'b0;
    #1;
    chk(32'(stat_valid), 32'(cv[i]));
    chk(32'(stat_out), 32'(RAW & cv[i]));
  endtask
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      failures++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {hsel, hwrite, go, buf_done, cmp_valid} = '0;
    {haddr, hwdata, htrans, lat, word_in, cmp_kind, cmp_raw} = '0;
    hsize = 3'h2;
    {failures, n_tests, cyc} = '0;
    repeat (2) tick;
    hresetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      run_desc(i);
      if (i == 0)
        xfer(1'b0, `RDBD_OFS_LENPOS, 32'h0040_0000);
    end
    xfer(1'b0, `RDBD_OFS_ADDR, w3[3]);
    xfer(1'b0, `RDBD_OFS_MODE, 32'h0000_0004);
    xfer(1'b0, `RDBD_OFS_STAT, 32'h09);
    xfer(1'b1, `RDBD_OFS_MASK, 32'h10);
    for (int i = 0; i < 5; i++) begin
      run_cmp(i);
      chk(32'(irq), 32'h1);
      xfer(1'b1, `RDBD_OFS_STAT, 32'h1F);
      #1;
      chk(32'(irq), 32'h0);
    end
    // irq still pending when reset lands in mid-run
    run_cmp(0);
    tick;
    hresetn <= 1'b0;
    tick;
    #1;
    chk(32'(irq), 32'h0);
    chk(32'(desc_ready), 32'h1);
    chk(32'(stat_valid), 32'h0);
    tick;
    hresetn <= 1'b1;
    xfer(1'b0, `RDBD_OFS_CTRL, 32'h1);
    xfer(1'b0, `RDBD_OFS_MASK, 32'h0);
    xfer(1'b0, `RDBD_OFS_STAT, 32'h0);
    xfer(1'b0, 8'h40, 32'h0);
    xfer(1'b1, `RDBD_OFS_LENPOS, 32'hFFFF_FFFF);
    xfer(1'b0, `RDBD_OFS_LENPOS, 32'h0);
    // masked completion leaves irq low but status sticky
    run_cmp(4);
    chk(32'(irq), 32'h0);
    xfer(1'b0, `RDBD_OFS_STAT, 32'h10);
    // disabled engine refuses descriptors and stray buffer completions
    xfer(1'b1, `RDBD_OFS_CTRL, 32'h0);
    #1;
    chk(32'(desc_ready), 32'h0);
    tick;
    buf_done <= 1'b1;
    tick;
    buf_done <= 1'b0;
    #1;
    chk(32'(desc_close), 32'h0);
    xfer(1'b1, `RDBD_OFS_CTRL, 32'h1);
    run_desc(1);
    print_verdict();
  end
endmodule
`default_nettype wire
